// *** papm_regs.vh ***
`ifndef PAPM_REGS_VH
`define PAPM_REGS_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define PAPM_OFF_AUTO_CFG    12'h000
`define PAPM_OFF_DIRECT_CFG  12'h004
`define PAPM_OFF_FDC_CTRL    12'h008
`define PAPM_OFF_PAR_CFG     12'h00c
`define PAPM_OFF_STATUS      12'h010
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PAPM_AUTO_FDC_BIT    0
`define PAPM_AUTO_PAR_BIT    3
`define PAPM_AUTO_UA_BIT     4
`define PAPM_AUTO_UB_BIT     5
`define PAPM_DIR_FDC_BIT     0
`define PAPM_DIR_UART_BIT    1
`define PAPM_DIR_PAR_BIT     2
`define PAPM_FDC_DSRPD_BIT   6
`define PAPM_FDC_SHUT_BIT    5
`define PAPM_PAR_ECPEN_BIT   0
`define PAPM_PAR_EPPEN_BIT   1
`define PAPM_PAR_ECR_LSB     4
// Extended control register mode codes
`define PAPM_ECR_SPP         3'h0
`define PAPM_ECR_BIDIR       3'h1
`define PAPM_ECR_EPP         3'h4
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define PAPM_RST_BYTE        8'h00
`define PAPM_MSR_IDLE        8'h80
`define PAPM_IDLE_TIME_US    10000
`define PAPM_CLK_MHZ         10
`define PAPM_IDLE_CYCLES     (`PAPM_IDLE_TIME_US * `PAPM_CLK_MHZ)
`endif

// *** papm_top.v ***
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "papm_regs.vh"

module papm_top #(
    parameter IDLE_CYCLES = `PAPM_IDLE_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [1:0]  motor_enable_bits,
    input  wire [7:0]  main_status_reg,
    input  wire        fdc_int,
    input  wire        head_unload_done,
    input  wire        motor_bit_set,
    input  wire        main_status_read,
    input  wire        data_reg_access,
    input  wire        fdc_soft_reset,
    input  wire [1:0]  motor_enable_int,
    input  wire [1:0]  drive_select_int,
    input  wire        write_data_int,
    input  wire        write_gate_int,
    input  wire        tx_holding_empty,
    input  wire        tx_shift_empty,
    input  wire        tx_buffer_write,
    input  wire        rx_fifo_empty,
    input  wire        rx_idle,
    input  wire        rx_data_in,
    input  wire        ring_ind_event,
    output reg         floppy_power_down_out,
    output reg         fdd_out_oe_n,
    output reg  [1:0]  motor_enable_outs,
    output reg  [1:0]  drive_select_outs,
    output reg         write_data_out,
    output reg         write_gate_out,
    output reg         fdc_auto_down,
    output reg         uart_direct_down,
    output reg         uart_tx_down,
    output reg         uart_rx_down,
    output reg         ring_ind_report,
    output reg         ecp_down,
    output reg         epp_down
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  auto_power_config_reg;
    reg  [7:0]  direct_power_config_reg;
    reg  [7:0]  fdc_ctrl_reg;
    reg  [7:0]  par_cfg_reg;
    reg  [23:0] idle_cnt_reg;
    reg         rx_line_reg;

    wire apb_wr = psel & penable & pwrite & pready;
    wire apb_rd_setup = psel & ~penable & ~pwrite;

    function valid_addr;
        input [11:0] a;
        begin
            valid_addr = (a == `PAPM_OFF_AUTO_CFG) || (a == `PAPM_OFF_DIRECT_CFG) ||
                         (a == `PAPM_OFF_FDC_CTRL) || (a == `PAPM_OFF_PAR_CFG) ||
                         (a == `PAPM_OFF_STATUS);
        end
    endfunction

    // ------------------------------------------------------------
    // APB slave: one wait state, answer on the second access edge
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~valid_addr(paddr);
            if (psel & penable & ~pready & ~pwrite) begin
                case (paddr)
                    `PAPM_OFF_AUTO_CFG:   prdata <= {24'h000000, auto_power_config_reg};
                    `PAPM_OFF_DIRECT_CFG: prdata <= {24'h000000, direct_power_config_reg};
                    `PAPM_OFF_FDC_CTRL:   prdata <= {24'h000000, fdc_ctrl_reg};
                    `PAPM_OFF_PAR_CFG:    prdata <= {24'h000000, par_cfg_reg};
                    `PAPM_OFF_STATUS:     prdata <= {25'h0000000, ring_ind_report, epp_down,
                                                     ecp_down, uart_rx_down, uart_tx_down,
                                                     fdc_auto_down, floppy_power_down_out};
                    default:              prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_power_config_reg   <= `PAPM_RST_BYTE;
            direct_power_config_reg <= `PAPM_RST_BYTE;
            fdc_ctrl_reg            <= `PAPM_RST_BYTE;
            par_cfg_reg             <= `PAPM_RST_BYTE;
        end else if (apb_wr) begin
            case (paddr)
                `PAPM_OFF_AUTO_CFG:   auto_power_config_reg   <= pwdata[7:0];
                `PAPM_OFF_DIRECT_CFG: direct_power_config_reg <= pwdata[7:0];
                `PAPM_OFF_FDC_CTRL:   fdc_ctrl_reg            <= pwdata[7:0];
                `PAPM_OFF_PAR_CFG:    par_cfg_reg             <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Floppy auto powerdown
    // ------------------------------------------------------------
    wire fdc_auto_en  = auto_power_config_reg[`PAPM_AUTO_FDC_BIT];
    wire drive_shutdown_bit = fdc_ctrl_reg[`PAPM_FDC_SHUT_BIT];
    wire dsr_pd_bit   = fdc_ctrl_reg[`PAPM_FDC_DSRPD_BIT];
    wire fdc_idle     = (motor_enable_bits == 2'h0) &&
                        (main_status_reg == `PAPM_MSR_IDLE) && !fdc_int &&
                        head_unload_done;
    wire fdc_wake     = motor_bit_set | main_status_read | data_reg_access |
                        fdc_soft_reset;
    wire timer_done   = (idle_cnt_reg >= IDLE_CYCLES[23:0]);

    // Timer restarts on any wake so a fresh 10 ms runs after each access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_reg  <= 24'h000000;
            fdc_auto_down <= 1'b0;
        end else if (!fdc_auto_en || fdc_wake) begin
            idle_cnt_reg  <= 24'h000000;
            fdc_auto_down <= 1'b0;
        end else begin
            if (!timer_done)
                idle_cnt_reg <= idle_cnt_reg + 24'h000001;
            if (timer_done && fdc_idle)
                fdc_auto_down <= 1'b1;
        end
    end

    // Priority decision, registered so the pin never glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            floppy_power_down_out <= 1'b0;
        end else if (drive_shutdown_bit) begin
            floppy_power_down_out <= 1'b1;
        end else if (fdc_auto_en) begin
            floppy_power_down_out <= fdc_auto_down;
        end else begin
            floppy_power_down_out <= dsr_pd_bit;
        end
    end

    // Drive pins: enable low while driven, high while the floppy is auto powered down
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fdd_out_oe_n      <= 1'b0;
            motor_enable_outs <= 2'h3;
            drive_select_outs <= 2'h3;
            write_data_out    <= 1'b1;
            write_gate_out    <= 1'b0;
        end else begin
            fdd_out_oe_n      <= fdc_auto_down;
            motor_enable_outs <= motor_enable_int;
            drive_select_outs <= drive_select_int;
            write_data_out    <= write_data_int;
            write_gate_out    <= write_gate_int;
        end
    end

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    wire uart_auto_en = auto_power_config_reg[`PAPM_AUTO_UA_BIT] &
                        auto_power_config_reg[`PAPM_AUTO_UB_BIT];
    wire rx_edge      = rx_data_in ^ rx_line_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_line_reg      <= 1'b1;
            uart_tx_down     <= 1'b0;
            uart_rx_down     <= 1'b0;
            uart_direct_down <= 1'b0;
            ring_ind_report  <= 1'b0;
        end else begin
            rx_line_reg      <= rx_data_in;
            uart_direct_down <= direct_power_config_reg[`PAPM_DIR_UART_BIT];
            ring_ind_report  <= ring_ind_event;
            if (!uart_auto_en || tx_buffer_write)
                uart_tx_down <= 1'b0;
            else if (tx_holding_empty && tx_shift_empty)
                uart_tx_down <= 1'b1;
            if (!uart_auto_en || rx_edge)
                uart_rx_down <= 1'b0;
            else if (rx_fifo_empty && rx_idle)
                uart_rx_down <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Parallel port: evaluated every cycle, so mode changes apply on the next clock
    // ------------------------------------------------------------
    wire       par_auto_en = auto_power_config_reg[`PAPM_AUTO_PAR_BIT];
    wire       ecp_en      = par_cfg_reg[`PAPM_PAR_ECPEN_BIT];
    wire       epp_en      = par_cfg_reg[`PAPM_PAR_EPPEN_BIT];
    wire [2:0] ecr_mode    = par_cfg_reg[`PAPM_PAR_ECR_LSB+2:`PAPM_PAR_ECR_LSB];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecp_down <= 1'b0;
            epp_down <= 1'b0;
        end else begin
            epp_down <= par_auto_en & (~epp_en |
                        (ecp_en & (ecr_mode != `PAPM_ECR_EPP)));
            ecp_down <= par_auto_en & (~ecp_en |
                        (ecr_mode == `PAPM_ECR_SPP) | (ecr_mode == `PAPM_ECR_BIDIR) |
                        (ecr_mode == `PAPM_ECR_EPP));
        end
    end

endmodule // papm_top

// *** papm_assertions.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Power-down checker
// ------------------------------------------------------------
module papm_checker (
    input logic pclk, presetn, fdc_auto_down, floppy_power_down_out, fdd_out_oe_n,
    input logic motor_bit_set, main_status_read, data_reg_access, fdc_soft_reset,
    input logic [1:0] motor_enable_bits,
    input logic [7:0] main_status_reg,
    input logic fdc_int, head_unload_done, tx_holding_empty, tx_shift_empty,
    input logic tx_buffer_write, uart_tx_down, rx_fifo_empty, rx_idle, rx_data_in,
    input logic uart_rx_down, ring_ind_event, ring_ind_report
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fpd_auto_high: assert property (fdc_auto_down |=> floppy_power_down_out)
        else $error("power-down pin low while floppy asleep");
    a_pins_float: assert property (fdc_auto_down |-> ##[0:1] fdd_out_oe_n)
        else $error("drive outputs not floated while asleep");
    a_fdc_sleep_cond: assert property ($rose(fdc_auto_down) |->
        $past(motor_enable_bits == 2'h0 && main_status_reg == 8'h80 && !fdc_int
        && head_unload_done)) else $error("floppy slept while busy");
    a_fdc_wake: assert property ((motor_bit_set || main_status_read || data_reg_access
        || fdc_soft_reset) |=> !fdc_auto_down) else $error("floppy did not wake");
    a_tx_sleep_cond: assert property ($rose(uart_tx_down) |->
        $past(tx_holding_empty && tx_shift_empty)) else $error("transmitter slept with data");
    a_tx_wake: assert property (tx_buffer_write |=> !uart_tx_down)
        else $error("transmitter did not wake");
    a_rx_sleep_cond: assert property ($rose(uart_rx_down) |->
        $past(rx_fifo_empty && rx_idle)) else $error("receiver slept while busy");
    a_rx_wake: assert property ($changed(rx_data_in) |=> !uart_rx_down)
        else $error("receiver did not wake on line edge");
    a_ring_report: assert property (ring_ind_event |=> ring_ind_report)
        else $error("ring event lost");
    cover property ($rose(fdc_auto_down));
    cover property ($rose(uart_tx_down));
    cover property ($fell(uart_rx_down));
endmodule // papm_checker
bind papm_top papm_checker i_chk (.*);

// *** papm_line_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial line far end: idles high, toggles on command
// ------------------------------------------------------------
module papm_line_model (
    input  logic pclk,
    input  logic kick,
    output logic rxd
);
    initial rxd = 1'b1;
    always @(posedge pclk) begin
        if (kick) rxd <= !rxd;
    end
endmodule // papm_line_model

// *** tb_peripheral_auto_powerdown.sv ***
`timescale 1ns/1ps
`include "papm_regs.vh"
module tb_peripheral_auto_powerdown;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fdc_int = 0, kick = 0;
    logic head_unload_done = 1, tx_holding_empty = 1, tx_shift_empty = 1, rx_idle = 1;
    logic tx_buffer_write = 0, rx_fifo_empty = 1, ring_ind_event = 0, e;
    logic [1:0] motor_enable_bits = 0, motor_enable_int = 0, x;
    logic [3:0] wk = 0;
    logic [7:0] main_status_reg = 8'h80;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, d;
    wire pready, pslverr, floppy_power_down_out, fdd_out_oe_n, write_data_out, write_gate_out;
    wire fdc_auto_down, uart_direct_down, uart_tx_down, uart_rx_down, ring_ind_report;
    wire ecp_down, epp_down, rx_data_in;
    wire [1:0] motor_enable_outs, drive_select_outs;
    int err_total = 0, num_checks = 0, cyc_cnt = 0;
    papm_top #(.IDLE_CYCLES(20)) i_dut (.motor_bit_set(wk[0]), .main_status_read(wk[1]),
        .data_reg_access(wk[2]), .fdc_soft_reset(wk[3]), .drive_select_int(2'h1),
        .write_data_int(1'b0), .write_gate_int(1'b1), .*);
    papm_line_model i_line (.pclk(pclk), .kick(kick), .rxd(rx_data_in));
    always #50 pclk = !pclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc_cnt++;
        motor_enable_int <= $urandom;
        if (cyc_cnt == 5000) begin
            err_total++;
            close_out;
        end
    end
    task chk(string nm, logic [31:0] s, logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task cyc(int n);
        repeat (n) @(posedge pclk);
    endtask
    // Starts one edge late so back-to-back calls never drive psel twice at once
    task apb(logic w, logic [11:0] a, logic [31:0] dd);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= dd;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (!pready);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function logic [1:0] par_exp(logic [2:0] m, logic [1:0] en);
        par_exp = {!en[0] || m == 0 || m == 1 || m == 4, !en[1] || (en[0] && m != 4)};
    endfunction
    initial begin
        void'($urandom(46));
        cyc(2);
        presetn <= 1;
        chk("fpd_rst", floppy_power_down_out, 0);
        chk("mtr_rst", motor_enable_outs, 3);
        for (int i = 0; i < 4; i++) begin
            d = $urandom & 32'hff;
            apb(1, 12'h4 * i, d);
            apb(0, 12'h4 * i, 0);
            chk("reg", r, d);
        end
        chk("ds_copy", drive_select_outs, 2'h1);
        chk("wd_copy", {write_gate_out, write_data_out}, 2'h2);
        apb(0, 12'h020, 0);
        chk("unmapped_err", e, 1);
        chk("unmapped_rd", r, 0);
        for (int i = 0; i < 4; i++) apb(1, 12'h4 * i, 0);
        for (int k = 0; k < 4; k++) begin
            apb(1, `PAPM_OFF_FDC_CTRL, k << 5);
            cyc(3);
            chk("fpd", floppy_power_down_out, k != 0);
        end
        apb(1, `PAPM_OFF_FDC_CTRL, 0);
        main_status_reg <= 8'h90;
        apb(1, `PAPM_OFF_AUTO_CFG, 1);
        cyc(40);
        chk("busy", fdc_auto_down, 0);
        main_status_reg <= 8'h80;
        // Timer ran out while busy, so restart it with a wake before timing the sleep
        wk[3] <= 1;
        cyc(1);
        wk[3] <= 0;
        cyc(2);
        for (int k = 0; k < 4; k++) begin
            cyc(10);
            chk("early", fdc_auto_down, 0);
            cyc(30);
            chk("asleep", {fdc_auto_down, floppy_power_down_out, fdd_out_oe_n}, 7);
            wk[k] <= 1;
            cyc(1);
            wk[k] <= 0;
            cyc(2);
            chk("wake", fdc_auto_down, 0);
        end
        apb(1, `PAPM_OFF_AUTO_CFG, 8'h10);
        cyc(30);
        chk("one_bit", uart_tx_down, 0);
        apb(1, `PAPM_OFF_AUTO_CFG, 8'h30);
        cyc(4);
        chk("uart_sleep", {uart_tx_down, uart_rx_down}, 3);
        ring_ind_event <= 1;
        cyc(2);
        chk("ring", ring_ind_report, 1);
        ring_ind_event <= 0;
        tx_buffer_write <= 1;
        tx_holding_empty <= 0;
        kick <= 1;
        rx_idle <= 0;
        cyc(1);
        tx_buffer_write <= 0;
        kick <= 0;
        cyc(4);
        chk("uart_wake", {uart_tx_down, uart_rx_down}, 0);
        apb(1, `PAPM_OFF_DIRECT_CFG, 2);
        cyc(3);
        chk("direct", uart_direct_down, 1);
        apb(1, `PAPM_OFF_AUTO_CFG, 8'h08);
        for (int j = 0; j < 16; j++) begin
            x = j[1:0];
            d = {j[3:2] == 3 ? 3'h3 : 3'(j[3:2] == 2 ? 4 : j[3:2]), 2'h0, x};
            apb(1, `PAPM_OFF_PAR_CFG, d);
            cyc(3);
            chk("par", {ecp_down, epp_down}, par_exp(d[6:4], x));
        end
        apb(1, `PAPM_OFF_AUTO_CFG, 0);
        cyc(3);
        chk("par_off", {ecp_down, epp_down}, 0);
        close_out;
    end
endmodule // tb_peripheral_auto_powerdown
